/* File: design/lme_defines.svh */
`ifndef LME_DEFINES_SVH
`define LME_DEFINES_SVH
// Notes on behaviour
// - Bit 0 is OR of link-error bitmap.
// - Bits 0, 1, 2 clear themselves.
// - Bit 1 follows all-station link failure.
// - Bit 2 is OR of remote-I/O bitmap.
// - Bit 3 flags an unregistered connected station.
// - Bit 3 latches at or above final station number.
// - Bit 4 latches bad rate switch until reset.
// - Bit 6 latches multi-station unit outside 49-64.
// - Bit 6 latches multi-station unit in four-point mode.
// - Bit 7 sets on non-volatile memory fault.
// - Bit 7 sets on write request outside edit mode.
// - Bit 8 sets when switches leave power-on value.
// - Bit 8 clears when switches match again.
// - Bit 15 sets on failed loop-back self-test.
// - Bit 15 clears only on power reset.
// - Fixed model identifier readable at index 0x1e.
// - Edit-mode status bit follows edit-mode selection.

// ==========================================================
// Register indices; byte address is four times the index.
`define LME_IDX_ERR 6'h1d
`define LME_IDX_MODEL 6'h1e
`define LME_IDX_CTRL 6'h20
`define LME_IDX_STAT 6'h21
`define LME_IDX_INT_STAT 6'h22
`define LME_IDX_INT_MASK 6'h23

// ==========================================================
// Field positions.
`define LME_CTRL_EE_WR 0
`define LME_CTRL_EDIT 1
`define LME_STAT_EDIT 0
`define LME_SW_FOURPT 0
`define LME_ERR_USED 16'h81df

// ==========================================================
// Reset values and limits.
`define LME_RST_16 16'h0000
`define LME_RST_32 32'h0000_0000
`define LME_RD_LO 7'h31
`define LME_RD_HI 7'h40
`define LME_RATE_BAD 2'h3
`define LME_CAP_DONE 2'h3
`define LME_CAP_TAKE 2'h2
`endif

/* File: design/lme_pkg.sv */
package lme_pkg;

	// ==========================================================
	// Whole state of the error flag block.
	typedef struct packed {
		logic [7:0] sw_s1;
		logic [7:0] sw_s2;
		logic [7:0] sw_cap;
		logic [1:0] cap_cnt;
		logic [1:0] rate_s1;
		logic [1:0] rate_s2;
		logic oor_hi;
		logic rd_err;
		logic rate_err;
		logic ee_err;
		logic hw_err;
		logic [15:0] err_word;
		logic [15:0] int_stat;
		logic [15:0] int_mask;
		logic [1:0] ctrl;
		logic ee_req_d;
		logic ee_pulse;
		logic ack;
		logic [31:0] dat;
	} lme_state_t;

	// Wishbone request signals grouped together.
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} lme_wb_req_t;

endpackage

/* File: design/lme_error_flags.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lme_defines.svh"

module lme_error_flags
	import lme_pkg::*;
#(
	parameter logic [15:0] MODEL_ID = 16'h5a5a // Arbitrary identifier value.
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire lme_wb_req_t wb_req,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq,
	input wire logic [63:0] link_err_map,
	input wire logic all_link_fail,
	input wire logic [63:0] rio_err_map,
	input wire logic oor_present,
	input wire logic [6:0] oor_station,
	input wire logic [6:0] final_station,
	input wire logic [1:0] rate_sw,
	input wire logic [7:0] op_switch,
	input wire logic rd_present,
	input wire logic [6:0] rd_station,
	input wire logic ee_fault,
	input wire logic ee_done,
	output logic ee_wr_req,
	input wire logic selftest_fail
);

	// ==========================================================
	// State registers.
	lme_state_t r_reg;
	lme_state_t r_next;

	logic [5:0] idx;
	logic acc;
	logic [15:0] wmask;

	// Word index and byte-lane write mask for the low half-word.
	assign idx = wb_req.adr[7:2];
	assign acc = wb_req.cyc && wb_req.stb;
	assign wmask = {{8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};

	// ==========================================================
	// Next-state logic.
	always_comb begin
		logic four_pt;
		logic cap_ok;
		logic wr;
		logic [15:0] e;
		logic [15:0] w1c;
		four_pt = 1'b0;
		cap_ok = 1'b0;
		wr = 1'b0;
		e = `LME_RST_16;
		w1c = `LME_RST_16;
		r_next = r_reg;

		// Two-stage synchronisers for switch pins.
		r_next.sw_s1 = op_switch;
		r_next.sw_s2 = r_reg.sw_s1;
		r_next.rate_s1 = rate_sw;
		r_next.rate_s2 = r_reg.rate_s1;

		// Switch snapshot is taken once the synchroniser holds pin values.
		cap_ok = (r_reg.cap_cnt == `LME_CAP_DONE);
		if (!cap_ok) begin
			r_next.cap_cnt = r_reg.cap_cnt + 2'h1;
		end
		if (r_reg.cap_cnt == `LME_CAP_TAKE) begin
			r_next.sw_cap = r_reg.sw_s2;
		end
		four_pt = cap_ok && r_reg.sw_cap[`LME_SW_FOURPT];

		// Station at or above the final number stays flagged until reset.
		if (oor_present && (oor_station >= final_station)) begin
			r_next.oor_hi = 1'b1;
		end

		// Unsupported rate code latches until reset.
		if (cap_ok && (r_reg.rate_s2 == `LME_RATE_BAD)) begin
			r_next.rate_err = 1'b1;
		end

		// Multi-station unit misplacement latches until reset.
		if (rd_present && ((rd_station < `LME_RD_LO) || (rd_station > `LME_RD_HI))) begin
			r_next.rd_err = 1'b1;
		end
		if (rd_present && four_pt) begin
			r_next.rd_err = 1'b1;
		end

		// Memory write request: forwarded in edit mode, refused otherwise.
		r_next.ee_req_d = r_reg.ctrl[`LME_CTRL_EE_WR];
		r_next.ee_pulse = 1'b0;
		if (ee_done) begin
			r_next.ee_err = 1'b0;
		end
		if (r_reg.ctrl[`LME_CTRL_EE_WR] && !r_reg.ee_req_d) begin
			if (r_reg.ctrl[`LME_CTRL_EDIT]) begin
				r_next.ee_pulse = 1'b1;
			end else begin
				r_next.ee_err = 1'b1;
			end
		end
		if (ee_fault) begin
			r_next.ee_err = 1'b1;
		end

		// Self-test failure latches until power reset.
		if (selftest_fail) begin
			r_next.hw_err = 1'b1;
		end

		// Assemble the error word from live causes and latches.
		e[0] = |link_err_map;
		e[1] = all_link_fail;
		e[2] = |rio_err_map;
		e[3] = r_next.oor_hi || (oor_present && (oor_station < final_station));
		e[4] = r_next.rate_err;
		e[6] = r_next.rd_err;
		e[7] = r_next.ee_err;
		e[8] = cap_ok && (r_reg.sw_s2 != r_reg.sw_cap);
		e[15] = r_next.hw_err;
		r_next.err_word = e & `LME_ERR_USED;

		// Bus write takes effect at the edge where ack is seen.
		wr = acc && wb_req.we && r_reg.ack;
		if (wr) begin
			unique case (idx)
				`LME_IDX_CTRL: begin
					if (wb_req.sel[0]) begin
						r_next.ctrl = wb_req.dat[1:0];
					end
				end
				`LME_IDX_INT_STAT: begin
					w1c = wb_req.dat[15:0] & wmask;
				end
				`LME_IDX_INT_MASK: begin
					r_next.int_mask = (r_reg.int_mask & ~wmask) | (wb_req.dat[15:0] & wmask);
				end
				default: begin
				end
			endcase
		end

		// Rising error bits set sticky status; a set beats a clear.
		r_next.int_stat = (r_reg.int_stat & ~w1c) | (r_next.err_word & ~r_reg.err_word);

		// One-cycle ack with read data registered alongside it.
		r_next.ack = acc && !r_reg.ack;
		r_next.dat = `LME_RST_32;
		if (acc && !r_reg.ack) begin
			unique case (idx)
				`LME_IDX_ERR: r_next.dat[15:0] = r_next.err_word;
				`LME_IDX_MODEL: r_next.dat[15:0] = MODEL_ID;
				`LME_IDX_CTRL: r_next.dat[1:0] = r_reg.ctrl;
				`LME_IDX_STAT: r_next.dat[`LME_STAT_EDIT] = r_reg.ctrl[`LME_CTRL_EDIT];
				`LME_IDX_INT_STAT: r_next.dat[15:0] = r_reg.int_stat;
				`LME_IDX_INT_MASK: r_next.dat[15:0] = r_reg.int_mask;
				default: r_next.dat = `LME_RST_32;
			endcase
		end
	end

	// ==========================================================
	// State register; power reset clears every latch, so nothing survives it.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs.
	assign wb_dat_o = r_reg.dat;
	assign wb_ack_o = r_reg.ack;
	assign ee_wr_req = r_reg.ee_pulse;
	assign irq = |(r_reg.int_stat & r_reg.int_mask);

	// ==========================================================
	// Checks.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	property p_link_part;
		(|link_err_map) |=> r_reg.err_word[0];
	endproperty
	a_link_part: assert property (p_link_part) else $error("link bit not set");

	property p_auto_clear;
		(!(|link_err_map) && !all_link_fail && !(|rio_err_map)) |=> (r_reg.err_word[2:0] == 3'h0);
	endproperty
	a_auto_clear: assert property (p_auto_clear) else $error("bits 0-2 did not clear");

	property p_all_fail;
		all_link_fail |=> r_reg.err_word[1];
	endproperty
	a_all_fail: assert property (p_all_fail) else $error("all-station bit not set");

	property p_rio;
		(|rio_err_map) |=> r_reg.err_word[2];
	endproperty
	a_rio: assert property (p_rio) else $error("remote I/O bit not set");

	property p_oor_low;
		(oor_present && (oor_station < final_station)) |=> r_reg.err_word[3];
	endproperty
	a_oor_low: assert property (p_oor_low) else $error("range bit not set");

	property p_oor_hold;
		(oor_present && (oor_station >= final_station)) |=> r_reg.err_word[3] [*3];
	endproperty
	a_oor_hold: assert property (p_oor_hold) else $error("range bit not held");

	property p_rate_hold;
		r_reg.err_word[4] |=> r_reg.err_word[4];
	endproperty
	a_rate_hold: assert property (p_rate_hold) else $error("rate bit dropped");

	property p_rd_range;
		(rd_present && ((rd_station < `LME_RD_LO) || (rd_station > `LME_RD_HI))) |=> r_reg.err_word[6] [*2];
	endproperty
	a_rd_range: assert property (p_rd_range) else $error("station unit bit not held");

	property p_rd_four;
		(rd_present && r_reg.cap_cnt == `LME_CAP_DONE && r_reg.sw_cap[`LME_SW_FOURPT]) |=> r_reg.err_word[6];
	endproperty
	a_rd_four: assert property (p_rd_four) else $error("four-point unit bit not set");

	property p_ee_fault;
		ee_fault |=> r_reg.err_word[7];
	endproperty
	a_ee_fault: assert property (p_ee_fault) else $error("memory fault bit not set");

	property p_ee_mode;
		(r_reg.ctrl[0] && !r_reg.ee_req_d && !r_reg.ctrl[1]) |=> (r_reg.err_word[7] && !ee_wr_req);
	endproperty
	a_ee_mode: assert property (p_ee_mode) else $error("request outside edit mode not flagged");

	property p_sw_change;
		(r_reg.cap_cnt == `LME_CAP_DONE && r_reg.sw_s2 != r_reg.sw_cap) |=> r_reg.err_word[8];
	endproperty
	a_sw_change: assert property (p_sw_change) else $error("switch change not flagged");

	property p_sw_back;
		(r_reg.cap_cnt == `LME_CAP_DONE && r_reg.sw_s2 == r_reg.sw_cap) |=> !r_reg.err_word[8];
	endproperty
	a_sw_back: assert property (p_sw_back) else $error("switch bit did not clear");

	property p_hw_set;
		selftest_fail |=> r_reg.err_word[15];
	endproperty
	a_hw_set: assert property (p_hw_set) else $error("hardware bit not set");

	property p_hw_keep;
		r_reg.err_word[15] |=> r_reg.err_word[15];
	endproperty
	a_hw_keep: assert property (p_hw_keep) else $error("hardware bit cleared");

	property p_model;
		(wb_ack_o && !wb_req.we && wb_req.adr[7:2] == `LME_IDX_MODEL) |-> (wb_dat_o[15:0] == MODEL_ID);
	endproperty
	a_model: assert property (p_model) else $error("model word wrong");

	property p_edit;
		(wb_ack_o && !wb_req.we && wb_req.adr[7:2] == `LME_IDX_STAT) |-> (wb_dat_o[0] == r_reg.ctrl[1]);
	endproperty
	a_edit: assert property (p_edit) else $error("edit status wrong");

	property p_unused;
		(r_reg.err_word[14:9] == 6'h00) && !r_reg.err_word[5];
	endproperty
	a_unused: assert property (p_unused) else $error("unused bit set");

	// ==========================================================
	// Bus, interrupt, latch, link-clear, memory request and snapshot checks.
	property p_ack_once;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack held longer than one cycle");

	property p_ack_answer;
		(wb_req.cyc && wb_req.stb && !wb_ack_o) |=> wb_ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("request not answered");

	property p_dat_idle;
		!wb_ack_o |-> (wb_dat_o == `LME_RST_32);
	endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");

	property p_int_rise;
		(((r_reg.err_word & ~$past(r_reg.err_word)) & ~r_reg.int_stat) == `LME_RST_16);
	endproperty
	a_int_rise: assert property (p_int_rise) else $error("rising error bit not recorded");

	property p_oor_keep;
		r_reg.oor_hi |=> r_reg.err_word[3];
	endproperty
	a_oor_keep: assert property (p_oor_keep) else $error("latched range bit dropped");

	property p_rate_set;
		(r_reg.cap_cnt == `LME_CAP_DONE && r_reg.rate_s2 == `LME_RATE_BAD) |=> r_reg.err_word[4];
	endproperty
	a_rate_set: assert property (p_rate_set) else $error("rate bit not set");

	property p_rd_hold;
		r_reg.err_word[6] |=> r_reg.err_word[6];
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("station unit bit dropped");

	property p_link_clear;
		!(|link_err_map) |=> !r_reg.err_word[0];
	endproperty
	a_link_clear: assert property (p_link_clear) else $error("link bit did not clear");

	property p_ee_fwd;
		(r_reg.ctrl[`LME_CTRL_EE_WR] && !r_reg.ee_req_d && r_reg.ctrl[`LME_CTRL_EDIT]) |=> ee_wr_req;
	endproperty
	a_ee_fwd: assert property (p_ee_fwd) else $error("request in edit mode not forwarded");

	property p_ee_pulse;
		ee_wr_req |=> !ee_wr_req;
	endproperty
	a_ee_pulse: assert property (p_ee_pulse) else $error("write request longer than one cycle");

	property p_ee_clear;
		(ee_done && !ee_fault && !(r_reg.ctrl[`LME_CTRL_EE_WR] && !r_reg.ee_req_d && !r_reg.ctrl[`LME_CTRL_EDIT])) |=> !r_reg.err_word[7];
	endproperty
	a_ee_clear: assert property (p_ee_clear) else $error("memory bit did not clear");

	property p_sw_keep;
		(r_reg.cap_cnt == `LME_CAP_DONE) |=> $stable(r_reg.sw_cap);
	endproperty
	a_sw_keep: assert property (p_sw_keep) else $error("switch snapshot changed while running");

endmodule
`default_nettype wire

/* File: bench/lme_cpu_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Processor side that reads and writes the buffer memory words.
module lme_cpu_model
	import lme_pkg::*;
(
	input wire logic clk,
	output lme_wb_req_t wb_req,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o
);
	// The bus starts idle.
	initial wb_req = '0;

	// One classic cycle, held until ack is sampled high, then one idle cycle.
	// Released address and data lines show inverted values so that stale data is never read as valid.
	task automatic access(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
		output logic [31:0] rdat);
		@(posedge clk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wdat};
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		wb_req <= '{cyc: 1'b0, stb: 1'b0, we: 1'b0, adr: ~adr, sel: 4'h0, dat: ~wdat};
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

/* File: bench/tb_link_master_error_flags.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lme_defines.svh"

// ==========================================================
// Self-checking bench for the error flag word.
module tb_link_master_error_flags;
	import lme_pkg::*;
	localparam logic [15:0] MID = 16'h1234; // Arbitrary identifier value.
	localparam logic [7:0] A_ERR = {`LME_IDX_ERR, 2'b00};
	localparam logic [7:0] A_MOD = {`LME_IDX_MODEL, 2'b00};
	localparam logic [7:0] A_CTL = {`LME_IDX_CTRL, 2'b00};
	localparam logic [7:0] A_STA = {`LME_IDX_STAT, 2'b00};
	localparam logic [7:0] A_IST = {`LME_IDX_INT_STAT, 2'b00};
	localparam logic [7:0] A_IMK = {`LME_IDX_INT_MASK, 2'b00};
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	lme_wb_req_t wb_req;
	logic [31:0] wb_dat_o, rd;
	logic wb_ack_o, irq, ee_wr_req;
	logic [63:0] link_err_map = '0, rio_err_map = '0;
	logic all_link_fail = 1'b0, oor_present = 1'b0, rd_present = 1'b0;
	logic ee_fault = 1'b0, ee_done = 1'b0, selftest_fail = 1'b0;
	logic [6:0] oor_station = '0, final_station = 7'h0a, rd_station = 7'h31;
	logic [1:0] rate_sw = '0;
	logic [7:0] op_switch = '0;
	int n_errors = 0, n_tests = 0, cyc_cnt = 0, n_wr = 0;

	// Clock at 100 MHz.
	always #5 clk = ~clk;

	lme_error_flags #(.MODEL_ID(MID)) lme_error_flags_i (.clk(clk), .sys_rst(sys_rst), .wb_req(wb_req),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .link_err_map(link_err_map),
		.all_link_fail(all_link_fail), .rio_err_map(rio_err_map), .oor_present(oor_present),
		.oor_station(oor_station), .final_station(final_station), .rate_sw(rate_sw),
		.op_switch(op_switch), .rd_present(rd_present), .rd_station(rd_station),
		.ee_fault(ee_fault), .ee_done(ee_done), .ee_wr_req(ee_wr_req), .selftest_fail(selftest_fail));

	lme_cpu_model lme_cpu_model_i (.clk(clk), .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

	// Counts forwarded memory write requests and cuts a hang short.
	always @(posedge clk) begin
		cyc_cnt++;
		if (ee_wr_req === 1'b1) n_wr++;
		if (cyc_cnt == 20000) begin
			n_errors++;
			print_verdict;
		end
	end

	task automatic print_verdict;
		$display("tests=%0d errors=%0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Lets flag inputs settle, then reads one word and compares it.
	task automatic rc(input logic [7:0] adr, input logic [31:0] exp);
		repeat (3) @(posedge clk);
		lme_cpu_model_i.access(1'b0, adr, 32'h0000_0000, rd);
		chk(rd, exp);
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		lme_cpu_model_i.access(1'b1, adr, d, rd);
	endtask

	// Power reset: latched flags other than bit 7, which ee_done also clears, are released only here.
	task automatic pwr_reset;
		@(posedge clk) sys_rst <= 1'b1;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (6) @(posedge clk);
	endtask

	task automatic t_link;
		@(posedge clk) link_err_map <= 64'h0000_0100_0000_0000;
		rc(A_ERR, 32'h0000_0001);
		@(posedge clk) link_err_map <= '0;
		all_link_fail <= 1'b1;
		rio_err_map <= 64'h8000_0000_0000_0000;
		rc(A_ERR, 32'h0000_0006);
		@(posedge clk) all_link_fail <= 1'b0;
		rio_err_map <= '0;
		rc(A_ERR, 32'h0000_0000);
		rc(A_IST, 32'h0000_0007);
		wr(A_IMK, 32'h0000_0002);
		chk(irq, 1'b1);
		wr(A_IST, 32'h0000_0007);
		rc(A_IST, 32'h0000_0000);
		chk(irq, 1'b0);
		$display("test link done");
	endtask

	task automatic t_oor;
		@(posedge clk) oor_present <= 1'b1;
		oor_station <= 7'h05;
		rc(A_ERR, 32'h0000_0008);
		@(posedge clk) oor_present <= 1'b0;
		rc(A_ERR, 32'h0000_0000);
		@(posedge clk) oor_present <= 1'b1;
		oor_station <= 7'h14;
		@(posedge clk) oor_present <= 1'b0;
		rc(A_ERR, 32'h0000_0008);
		pwr_reset;
		rc(A_ERR, 32'h0000_0000);
		$display("test range done");
	endtask

	task automatic t_sw;
		@(posedge clk) rate_sw <= 2'h3;
		rd_present <= 1'b1;
		rd_station <= 7'h30;
		op_switch <= 8'h04;
		rc(A_ERR, 32'h0000_0150);
		@(posedge clk) rate_sw <= 2'h0;
		rd_present <= 1'b0;
		op_switch <= 8'h00;
		rc(A_ERR, 32'h0000_0050);
		pwr_reset;
		@(posedge clk) rd_present <= 1'b1;
		rd_station <= 7'h40;
		rc(A_ERR, 32'h0000_0000);
		@(posedge clk) op_switch <= 8'h01;
		rd_station <= 7'h31;
		pwr_reset;
		rc(A_ERR, 32'h0000_0040);
		@(posedge clk) rd_present <= 1'b0;
		op_switch <= 8'h00;
		pwr_reset;
		$display("test switch done");
	endtask

	task automatic t_ee;
		@(posedge clk) ee_fault <= 1'b1;
		@(posedge clk) ee_fault <= 1'b0;
		rc(A_ERR, 32'h0000_0080);
		@(posedge clk) ee_done <= 1'b1;
		@(posedge clk) ee_done <= 1'b0;
		rc(A_ERR, 32'h0000_0000);
		wr(A_CTL, 32'h0000_0001);
		rc(A_ERR, 32'h0000_0080);
		chk(n_wr, 0);
		wr(A_CTL, 32'h0000_0000);
		wr(A_CTL, 32'h0000_0002);
		rc(A_STA, 32'h0000_0001);
		wr(A_CTL, 32'h0000_0003);
		repeat (4) @(posedge clk);
		chk(n_wr, 1);
		@(posedge clk) ee_done <= 1'b1;
		@(posedge clk) ee_done <= 1'b0;
		rc(A_ERR, 32'h0000_0000);
		wr(A_CTL, 32'h0000_0000);
		rc(A_STA, 32'h0000_0000);
		$display("test memory done");
	endtask

	task automatic t_hw;
		rc(A_MOD, {16'h0000, MID});
		wr(A_MOD, 32'h0000_0000);
		rc(A_MOD, {16'h0000, MID});
		rc(8'hfc, 32'h0000_0000);
		@(posedge clk) selftest_fail <= 1'b1;
		@(posedge clk) selftest_fail <= 1'b0;
		rc(A_ERR, 32'h0000_8000);
		wr(A_ERR, 32'h0000_ffff);
		repeat (50) @(posedge clk);
		rc(A_ERR, 32'h0000_8000);
		$display("test hardware done");
	endtask

	// Main sequence.
	initial begin
		pwr_reset;
		t_link;
		t_oor;
		t_sw;
		t_ee;
		t_hw;
		print_verdict;
	end
endmodule
`default_nettype wire
